// *** shared/fsp_pkg.sv ***
// constants for the flash self-programming sequencer
package fsp_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] FSP_REG_CTRL   = 4'h0;
  localparam logic [3:0] FSP_REG_STATUS = 4'h1;
  localparam logic [3:0] FSP_REG_IRQ_ST = 4'h2;
  localparam logic [3:0] FSP_REG_IRQ_MK = 4'h3;

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int FSP_CTRL_READ_EN = 4;

  // ----------------------------------------
  // status / interrupt fields
  // ----------------------------------------
  localparam int FSP_ST_BUSY      = 0;
  localparam int FSP_ST_HALT      = 1;
  localparam int FSP_IRQ_DONE     = 0;
  localparam int FSP_IRQ_REFUSED  = 1;
  localparam int FSP_IRQ_W        = 2;

  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [7:0] FSP_CTRL_RST = 8'h00;
  localparam logic [1:0] FSP_MASK_RST = 2'h0;
  localparam int FSP_PAGE_OP_NS      = 4000;
  localparam int FSP_CLK_NS          = 8;
  localparam int FSP_PAGE_OP_CYC     = FSP_PAGE_OP_NS / FSP_CLK_NS;

  // ----------------------------------------
  // operation codes from the core
  // ----------------------------------------
  localparam logic [1:0] FSP_OP_LOAD  = 2'h0;
  localparam logic [1:0] FSP_OP_ERASE = 2'h1;
  localparam logic [1:0] FSP_OP_WRITE = 2'h2;

  typedef enum logic [2:0] {
    FSP_IDLE = 3'h1,
    FSP_RWW  = 3'h2,
    FSP_NO_READ_WHILE_WRITE_SECTION = 3'h4
  } fsp_state_e;

endpackage : fsp_pkg

// *** rtl/fsp_sequencer.sv ***
// flash self-programming sequencer with rww/no_read_while_write_section split and boot locks
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps

// Operation
// [RULE_01] program requests only act when executed from the boot-loader section
// [RULE_02] boot-loader requests may target any page, boot section included
// [RULE_03] fuse-sized boundary splits application and boot-loader sections
// [RULE_04] application protection follows lock pair zero
// [RULE_05] boot-loader protection follows lock pair one
// [RULE_06] fixed rww/no_read_while_write_section split; no_read_while_write_section always holds the boot section
// [RULE_07] rww page operation keeps the cpu running, no_read_while_write_section readable
// [RULE_08] no_read_while_write_section page operation halts the cpu throughout; nothing readable
// [RULE_09] software never touches the rww section while it is programmed
// [RULE_10] busy flag reads one while the rww section is blocked
// [RULE_11] software clears the busy flag before running rww code
// [RULE_12] busy flag sets when an rww erase or write starts
// [RULE_13] busy clears on read-enable write after completion, or page load
// [RULE_14] application lock pair decodes write and read blocking
module fsp_sequencer
  import fsp_pkg::*;
#(
  parameter int ADDR_W    = 12,
  parameter int NO_READ_WHILE_WRITE_SECTION_BASE = 12'hc00,
  parameter int OP_CYCLES = FSP_PAGE_OP_CYC
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // fuses and lock bits
  input  wire logic [1:0]        boot_size_fuses,
  input  wire logic              app_lock_bit_hi,
  input  wire logic              app_lock_bit_lo,
  input  wire logic              boot_lock_bit_hi,
  input  wire logic              boot_lock_bit_lo,
  // core program requests
  input  wire logic              prog_req,
  input  wire logic [1:0]        prog_op,
  input  wire logic [ADDR_W-1:0] prog_addr,
  input  wire logic [ADDR_W-1:0] exec_pc,
  // core load-program reads
  input  wire logic              load_req,
  input  wire logic [ADDR_W-1:0] load_addr,
  output logic                   load_allow,
  // flash array
  output logic                   flash_start,
  output logic [1:0]             flash_op,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic                   cpu_halt,
  output logic                   rww_read_ok,
  // register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  output logic                   irq
);

  // ----------------------------------------
  // section decode
  // ----------------------------------------
  logic [ADDR_W-1:0] boot_base;
  logic pc_in_boot, tgt_in_boot, tgt_in_no_read_while_write_section, ld_in_boot;
  logic app_wr_blk, app_rd_blk, boot_wr_blk, boot_rd_blk;
  logic is_prog, accept, refuse;
  // declared here because the accept term reads the state
  fsp_state_e state_q, state_d;

  // [RULE_03] boot boundary from fuses
  always_comb begin
    case (boot_size_fuses)
      2'h0:    boot_base = ADDR_W'(NO_READ_WHILE_WRITE_SECTION_BASE);
      2'h1:    boot_base = ADDR_W'(NO_READ_WHILE_WRITE_SECTION_BASE + (1 << (ADDR_W - 3)));
      2'h2:    boot_base = ADDR_W'(NO_READ_WHILE_WRITE_SECTION_BASE + (3 << (ADDR_W - 4)));
      default: boot_base = ADDR_W'({ADDR_W{1'b1}} - (1 << (ADDR_W - 5)) + 1);
    endcase
  end

  assign pc_in_boot  = exec_pc >= boot_base;
  assign tgt_in_boot = prog_addr >= boot_base;
  assign ld_in_boot  = load_addr >= boot_base;
  // [RULE_06] fixed no_read_while_write_section boundary, boot always above it
  assign tgt_in_no_read_while_write_section = prog_addr >= ADDR_W'(NO_READ_WHILE_WRITE_SECTION_BASE);

  // [RULE_04] application pair, 0 means programmed
  // [RULE_14] lo blocks writes, hi blocks boot-side reads
  assign app_wr_blk  = ~app_lock_bit_lo;
  assign app_rd_blk  = ~app_lock_bit_hi;
  // [RULE_05] boot pair, same layout
  assign boot_wr_blk = ~boot_lock_bit_lo;
  assign boot_rd_blk = ~boot_lock_bit_hi;

  assign is_prog = prog_req && (prog_op != FSP_OP_LOAD);
  // [RULE_01] only from boot; [RULE_02] any target subject to locks
  assign accept  = is_prog && pc_in_boot && (state_q == FSP_IDLE)
                   && !(tgt_in_boot ? boot_wr_blk : app_wr_blk);
  assign refuse  = is_prog && !accept;

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  logic [31:0] cnt_q, cnt_d;
  logic busy_q, busy_d, done;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    done    = 1'b0;
    case (state_q)
      FSP_IDLE: begin
        if (accept) begin
          // [RULE_07] [RULE_08] choose run or halt by target
          state_d = tgt_in_no_read_while_write_section ? FSP_NO_READ_WHILE_WRITE_SECTION : FSP_RWW;
          cnt_d   = 32'(OP_CYCLES - 1);
        end
      end
      FSP_RWW, FSP_NO_READ_WHILE_WRITE_SECTION: begin
        if (cnt_q == 32'h0) begin
          state_d = FSP_IDLE;
          done    = 1'b1;
        end else begin
          cnt_d = cnt_q - 32'h1;
        end
      end
      default: state_d = FSP_IDLE;
    endcase
  end

  // ----------------------------------------
  // busy flag
  // ----------------------------------------
  logic ctl_wr, rd_en_wr, ld_start;
  assign ctl_wr   = reg_wr && (reg_addr == FSP_REG_CTRL);
  assign rd_en_wr = ctl_wr && reg_wdata[FSP_CTRL_READ_EN];
  assign ld_start = prog_req && (prog_op == FSP_OP_LOAD) && pc_in_boot;

  always_comb begin
    busy_d = busy_q;
    // [RULE_13] clear after completion by read-enable, or by page load
    if ((rd_en_wr && state_q == FSP_IDLE) || ld_start)
      busy_d = 1'b0;
    // [RULE_12] set on rww erase/write start; set wins
    if (accept && !tgt_in_no_read_while_write_section)
      busy_d = 1'b1;
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  logic [FSP_IRQ_W-1:0] ist_q, ist_d, imk_q, imk_d, ev;
  assign ev = {refuse, done};

  always_comb begin
    ist_d = ist_q;
    imk_d = imk_q;
    if (reg_wr && reg_addr == FSP_REG_IRQ_ST)
      ist_d = ist_q & ~reg_wdata[FSP_IRQ_W-1:0];
    // set beats clear in the same cycle
    ist_d = ist_d | ev;
    if (reg_wr && reg_addr == FSP_REG_IRQ_MK)
      imk_d = reg_wdata[FSP_IRQ_W-1:0];
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [7:0] rdata_d;
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        // [RULE_10] busy reads one while rww blocked
        FSP_REG_CTRL:   rdata_d = {1'b0, busy_q, 6'h00};
        FSP_REG_STATUS: rdata_d = {6'h00, cpu_halt, busy_q};
        FSP_REG_IRQ_ST: rdata_d = {6'h00, ist_q};
        FSP_REG_IRQ_MK: rdata_d = {6'h00, imk_q};
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  logic              fs_d;
  logic [1:0]        fop_d;
  logic [ADDR_W-1:0] fad_d;
  assign fs_d  = accept;
  assign fop_d = accept ? prog_op : flash_op;
  assign fad_d = accept ? prog_addr : flash_addr;

  // sequencer registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= FSP_IDLE;
      cnt_q   <= 32'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // busy flag register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  // interrupt registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ist_q <= 2'h0;
      imk_q <= FSP_MASK_RST;
    end else begin
      ist_q <= ist_d;
      imk_q <= imk_d;
    end
  end

  // registered outputs; read data is zero outside its cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata   <= 8'h00;
      flash_start <= 1'b0;
      flash_op    <= 2'h0;
      flash_addr  <= '0;
    end else begin
      reg_rdata   <= rdata_d;
      flash_start <= fs_d;
      flash_op    <= fop_d;
      flash_addr  <= fad_d;
    end
  end

  // ----------------------------------------
  // core-facing outputs
  // ----------------------------------------
  // [RULE_08] halt for the whole no_read_while_write_section operation
  assign cpu_halt    = (state_q == FSP_NO_READ_WHILE_WRITE_SECTION);
  // [RULE_07] rww code unreadable while busy; software must respect it
  assign rww_read_ok = !busy_q && !cpu_halt;
  // [RULE_14] boot-side load of app blocked by hi; app-side load of boot too
  assign load_allow  = load_req && !cpu_halt
                       && !(ld_in_boot ? (!pc_in_boot && boot_rd_blk)
                                       : (pc_in_boot && app_rd_blk))
                       && (ld_in_boot || load_addr >= ADDR_W'(NO_READ_WHILE_WRITE_SECTION_BASE) || !busy_q);
  assign irq         = |(ist_q & imk_q);

  // ----------------------------------------
  // op length watch
  // ----------------------------------------
  // counts cycles of the running op so checks need no long repetition
  logic [31:0] run_q, run_d;
  always_comb begin
    run_d = (state_q == FSP_IDLE) ? 32'h0 : run_q + 32'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      run_q <= 32'h0;
    end else begin
      run_q <= run_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_app_refuse: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_01]
    (is_prog && !pc_in_boot) |=> !flash_start)
    else $error("program request from application section was started");

  chk_busy_set: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_12]
    (accept && !tgt_in_no_read_while_write_section) |=> busy_q && state_q == FSP_RWW)
    else $error("busy flag not set on rww operation");

  chk_halt_span: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_08]
    (accept && tgt_in_no_read_while_write_section) |=> cpu_halt [*8])
    else $error("cpu not halted through no_read_while_write_section operation");

  chk_rww_run: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_07]
    (state_q == FSP_RWW) |-> !cpu_halt)
    else $error("cpu halted during rww operation");

  chk_busy_read: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_10]
    (reg_rd && reg_addr == FSP_REG_CTRL) |=> reg_rdata[6] == $past(busy_q))
    else $error("busy flag read back wrong");

  chk_busy_clear: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_13]
    (ld_start && !accept) |=> !busy_q)
    else $error("page load did not clear busy");

  chk_app_lock: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_14]
    (is_prog && !tgt_in_boot && !app_lock_bit_lo) |-> !accept)
    else $error("locked application section accepted a write");

  chk_boot_lock: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_05]
    (is_prog && tgt_in_boot && !boot_lock_bit_lo) |-> !accept)
    else $error("locked boot section accepted a write");

  chk_start_pulse: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_01]
    accept |=> flash_start && flash_addr == $past(prog_addr))
    else $error("accepted request did not start the flash");

  chk_start_only: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_01]
    !accept |=> !flash_start)
    else $error("flash started without an accepted request");

  chk_boot_self: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_02]
    (is_prog && pc_in_boot && tgt_in_boot && boot_lock_bit_lo && state_q == FSP_IDLE)
    |-> accept)
    else $error("unlocked boot section refused its own write");

  chk_boot_above: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_06]
    boot_base >= ADDR_W'(NO_READ_WHILE_WRITE_SECTION_BASE))
    else $error("boot section reaches below the no_read_while_write_section boundary");

  chk_pc_boot: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_03]
    (exec_pc < ADDR_W'(NO_READ_WHILE_WRITE_SECTION_BASE)) |-> !pc_in_boot)
    else $error("low address taken as boot section");

  chk_op_bound: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_08]
    (state_q != FSP_IDLE) |-> run_q < 32'(OP_CYCLES))
    else $error("page operation ran too long");

  chk_halt_full: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_08]
    (state_q == FSP_NO_READ_WHILE_WRITE_SECTION && run_q < 32'(OP_CYCLES - 1)) |=> cpu_halt)
    else $error("cpu released before no_read_while_write_section operation ended");

  chk_op_end: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_08]
    (state_q == FSP_NO_READ_WHILE_WRITE_SECTION && run_q == 32'(OP_CYCLES - 1)) |=> !cpu_halt)
    else $error("cpu still halted after no_read_while_write_section operation");

  chk_busy_blocks: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_10]
    (busy_q || (load_req && load_addr < ADDR_W'(NO_READ_WHILE_WRITE_SECTION_BASE) && busy_q))
    |-> !rww_read_ok && !(load_req && load_addr < ADDR_W'(NO_READ_WHILE_WRITE_SECTION_BASE) && load_allow))
    else $error("rww section readable while busy");

  chk_no_read_while_write_section_load: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_07]
    (state_q == FSP_RWW && load_req && ld_in_boot && pc_in_boot) |-> load_allow)
    else $error("no_read_while_write_section read refused during rww operation");

  chk_busy_hold: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_12]
    (busy_q && !rd_en_wr && !ld_start) |=> busy_q)
    else $error("busy flag dropped without a clear");

  chk_app_read_lock: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_14]
    (load_req && pc_in_boot && !ld_in_boot && !app_lock_bit_hi) |-> !load_allow)
    else $error("locked application section was read");

endmodule : fsp_sequencer

// *** verification/fsp_core_model.sv ***
// behavioural core model issuing store and load program requests
`timescale 1ns/1ps
module fsp_core_model
  import fsp_pkg::*;
#(
  parameter int NO_READ_WHILE_WRITE_SECTION_BASE = 12'hc00
) (
  // clock and status
  input  wire logic   ref_clk,
  input  wire logic   cpu_halt,
  input  wire logic   rww_read_ok,
  // requests
  output logic        prog_req,
  output logic [1:0]  prog_op,
  output logic [11:0] prog_addr,
  output logic [11:0] exec_pc,
  output logic        load_req,
  output logic [11:0] load_addr
);
  initial begin
    prog_req = 1'b0;
    prog_op = 2'h0;
    prog_addr = 12'h000;
    exec_pc = 12'h000;
    load_req = 1'b0;
    load_addr = 12'h000;
  end
  task automatic issue(input logic [1:0] op, input logic [11:0] ad, input logic [11:0] pc);
    while (cpu_halt === 1'b1) @(posedge ref_clk);
    @(posedge ref_clk);
    prog_req <= 1'b1;
    prog_op <= op;
    prog_addr <= ad;
    exec_pc <= pc;
    @(posedge ref_clk);
    prog_req <= 1'b0;
    prog_addr <= ~ad;
  endtask : issue
  task automatic load(input logic [11:0] pc, input logic [11:0] ad);
    // no reads of the rww section while it is blocked
    if (ad < NO_READ_WHILE_WRITE_SECTION_BASE && rww_read_ok !== 1'b1) return;
    @(posedge ref_clk);
    load_req <= 1'b1;
    load_addr <= ad;
    exec_pc <= pc;
    #1;
  endtask : load
  task automatic unload();
    @(posedge ref_clk);
    load_req <= 1'b0;
    load_addr <= ~load_addr;
  endtask : unload
endmodule : fsp_core_model

// *** verification/flash_rww_self_program_bench.sv ***
// self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ps
module flash_rww_self_program_bench import fsp_pkg::*;;
  localparam int OPC = 10;
  logic ref_clk, reset, prog_req, load_req, load_allow, flash_start;
  logic cpu_halt, rww_read_ok, reg_wr, reg_rd, irq, rd_seen;
  logic app_lock_bit_hi, app_lock_bit_lo, boot_lock_bit_hi, boot_lock_bit_lo;
  logic [1:0]  boot_size_fuses;
  logic [1:0]  prog_op, flash_op;
  logic [11:0] prog_addr, exec_pc, load_addr, flash_addr, a;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [7:0]  exp_q[$];
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  fsp_sequencer #(.OP_CYCLES(OPC)) fsp_sequencer_i (.ref_clk, .reset,
    .boot_size_fuses, .app_lock_bit_hi, .app_lock_bit_lo,
    .boot_lock_bit_hi, .boot_lock_bit_lo, .prog_req, .prog_op,
    .prog_addr, .exec_pc, .load_req, .load_addr, .load_allow, .flash_start,
    .flash_op, .flash_addr, .cpu_halt, .rww_read_ok, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq);
  fsp_core_model fsp_core_model_i (.ref_clk, .cpu_halt, .rww_read_ok, .prog_req,
    .prog_op, .prog_addr, .exec_pc, .load_req, .load_addr);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] ad, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // watcher: read data stand in the cycle after the strobe
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    rd_seen <= reg_rd;
    if (rd_seen === 1'b1) check(reg_rdata, exp_q.pop_front());
    if (cyc == 2000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    {reset, rd_seen, app_lock_bit_hi, app_lock_bit_lo} = 4'h b;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 14'h0000;
    {boot_size_fuses, boot_lock_bit_hi, boot_lock_bit_lo} = 4'h3;
    void'($urandom(32'heb1a95dd));
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) rd(i[3:0], 8'h00);
    // application code cannot program
    fsp_core_model_i.issue(FSP_OP_ERASE, 12'h040, 12'h100);
    @(negedge ref_clk);
    check(flash_start, 1'b0);
    rd(FSP_REG_IRQ_ST, 8'h02);
    wr(FSP_REG_IRQ_ST, 8'h02);
    rd(FSP_REG_IRQ_ST, 8'h00);
    // rww page erase keeps the core running
    a = 12'($urandom % 3072);
    fsp_core_model_i.issue(FSP_OP_ERASE, a, 12'hc00);
    @(negedge ref_clk);
    check({flash_start, flash_op, flash_addr}, {1'b1, FSP_OP_ERASE, a});
    check({cpu_halt, rww_read_ok}, 2'b00);
    rd(FSP_REG_STATUS, 8'h01);
    repeat (OPC + 2) @(posedge ref_clk);
    rd(FSP_REG_CTRL, 8'h40);
    rd(FSP_REG_IRQ_ST, 8'h01);
    check(irq, 1'b0);
    wr(FSP_REG_IRQ_MK, 8'h01);
    @(negedge ref_clk);
    check(irq, 1'b1);
    wr(FSP_REG_IRQ_ST, 8'h01);
    @(negedge ref_clk);
    check(irq, 1'b0);
    wr(FSP_REG_CTRL, 8'h10);
    rd(FSP_REG_STATUS, 8'h00);
    // boot section rewrites itself, core halted throughout
    fsp_core_model_i.issue(FSP_OP_WRITE, 12'hc40, 12'hc00);
    @(negedge ref_clk);
    check({flash_start, cpu_halt, rww_read_ok}, 3'b110);
    repeat (OPC - 2) @(negedge ref_clk);
    check(cpu_halt, 1'b1);
    repeat (3) @(negedge ref_clk);
    check(cpu_halt, 1'b0);
    rd(FSP_REG_STATUS, 8'h00);
    // every application lock code
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      {app_lock_bit_hi, app_lock_bit_lo} <= k[1:0];
      fsp_core_model_i.load(12'hc00, 12'h080);
      check(load_allow, k[1]);
      fsp_core_model_i.unload();
      fsp_core_model_i.issue(FSP_OP_ERASE, 12'h080, 12'hc00);
      @(negedge ref_clk);
      check(flash_start, k[0]);
      repeat (OPC + 2) @(posedge ref_clk);
      fsp_core_model_i.issue(FSP_OP_LOAD, 12'h080, 12'hc00);
      @(negedge ref_clk);
      check(rww_read_ok, 1'b1);
    end
    // boot lock pair and boot size fuses
    @(posedge ref_clk);
    boot_lock_bit_lo <= 1'b0;
    fsp_core_model_i.issue(FSP_OP_WRITE, 12'hc40, 12'hc00);
    @(negedge ref_clk);
    check(flash_start, 1'b0);
    @(posedge ref_clk);
    {boot_lock_bit_hi, boot_lock_bit_lo, boot_size_fuses} <= 4'h5;
    fsp_core_model_i.load(12'h100, 12'he40);
    check(load_allow, 1'b0);
    fsp_core_model_i.unload();
    fsp_core_model_i.issue(FSP_OP_ERASE, 12'h080, 12'hc00);
    @(negedge ref_clk);
    check(flash_start, 1'b0);
    fsp_core_model_i.issue(FSP_OP_ERASE, 12'h080, 12'he00);
    @(negedge ref_clk);
    check(flash_start, 1'b1);
    give_verdict();
  end
endmodule : flash_rww_self_program_bench
